/* File: rtl/bmm_memory_map.sv */
`timescale 1ns/100ps
module bmm_memory_map (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    // host access from the serial engine
    input  wire bmm_pkg::bmm_req_t      req,
    output logic [7:0]                  rdata,
    input  wire logic                   lock_cmd,
    input  wire logic                   unlock_cmd,
    // serial data pin level, sampled
    input  wire logic                   data_pin,
    // analog side
    input  wire bmm_pkg::bmm_meas_t     meas,
    input  wire bmm_pkg::bmm_defaults_t defaults,
    input  wire logic                   charge_fault,
    input  wire logic                   discharge_fault,
    // control outputs
    output logic                        sleep_request,
    output logic                        cell_revive_mode,
    output logic                        upper_cell_bleed,
    output logic                        lower_cell_bleed,
    output logic                        charge_fet_on,
    output logic                        discharge_fet_on,
    output logic                        page_locked
);

    // register state
    logic [7:0]  ctl_q, ctl_d;
    logic [7:0]  dly_q, dly_d;
    logic [7:0]  warn_q, warn_d;
    logic [15:0] ident_q, ident_d;
    logic [7:0]  cfg_q, cfg_d;
    logic [7:0]  integ_q, integ_d;
    logic [15:0] charge_tot_q, charge_tot_d;
    logic [15:0] discharge_tot_q, discharge_tot_d;
    logic        lock_q, lock_d;
    logic [7:0]  user_q [bmm_pkg::PAGE_BYTES];
    logic [7:0]  user_d [bmm_pkg::PAGE_BYTES];
    logic        pin_q, pin_d;
    logic [bmm_pkg::DISC_CNT_W-1:0] low_cnt_q, low_cnt_d;
    logic        charge_fet_q, charge_fet_d;
    logic        discharge_fet_q, discharge_fet_d;
    logic [7:0]  rdata_q, rdata_d;

    logic        wr_p0, wr_p2, wr_p3, fall_edge, disconnect;
    logic [7:0]  ctl_rd;

    // write qualifiers per page; no supply gating, bus power suffices
    // supply independent
    assign wr_p0 = req.wr && (req.page == bmm_pkg::PAGE_PROT) && !lock_q;
    assign wr_p2 = req.wr && (req.page == bmm_pkg::PAGE_ACC);
    assign wr_p3 = req.wr && (req.page == bmm_pkg::PAGE_USER);

    // falling edge and long-low detection on the data pin
    assign fall_edge  = pin_q && !data_pin;
    assign disconnect = (low_cnt_q == bmm_pkg::DISC_CNT_W'(bmm_pkg::DISCONNECT_CYCLES));

    // control byte as read: pin mirrors replace stored bits 3 and 2
    always_comb begin
        ctl_rd = ctl_q;
        ctl_rd[bmm_pkg::CTL_CHARGE_PIN]    = charge_fet_q;
        ctl_rd[bmm_pkg::CTL_DISCHARGE_PIN] = discharge_fet_q;
    end

    // next-state for all writable storage
    always_comb begin
        ctl_d      = ctl_q;
        dly_d      = dly_q;
        warn_d     = warn_q;
        ident_d    = ident_q;
        cfg_d      = cfg_q;
        integ_d    = integ_q;
        charge_tot_d    = charge_tot_q;
        discharge_tot_d = discharge_tot_q;
        lock_d     = lock_q;
        user_d     = user_q;
        pin_d      = data_pin;
        low_cnt_d  = low_cnt_q;
        if (lock_cmd) begin
            lock_d = 1'b1;
        end else if (unlock_cmd) begin
            lock_d = 1'b0;
        end
        // silent discard; a locked write never reaches wr_p0
        if (wr_p0) begin
            unique case (req.ofs)
                bmm_pkg::OFS_PACK_CONTROL: begin
                    ctl_d = req.wdata;
                    ctl_d[bmm_pkg::CTL_CHARGE_PIN]    = ctl_q[bmm_pkg::CTL_CHARGE_PIN];
                    ctl_d[bmm_pkg::CTL_DISCHARGE_PIN] = ctl_q[bmm_pkg::CTL_DISCHARGE_PIN];
                end
                bmm_pkg::OFS_DELAY_TIMING:   dly_d = req.wdata;
                bmm_pkg::OFS_WARN_THRESHOLD: warn_d = req.wdata;
                default: ;
            endcase
        end
        if (wr_p2) begin
            unique case (req.ofs)
                bmm_pkg::OFS_INTEGRATED:   integ_d = req.wdata;
                bmm_pkg::OFS_CONFIG:       cfg_d = req.wdata | bmm_pkg::CFG_FIXED_ONES;
                bmm_pkg::OFS_CHARGE_LO:    charge_tot_d[7:0] = req.wdata;
                bmm_pkg::OFS_CHARGE_HI:    charge_tot_d[15:8] = req.wdata;
                bmm_pkg::OFS_DISCHARGE_LO: discharge_tot_d[7:0] = req.wdata;
                bmm_pkg::OFS_DISCHARGE_HI: discharge_tot_d[15:8] = req.wdata;
                default: ;
            endcase
        end
        if (wr_p3) begin
            user_d[req.ofs] = req.wdata;
        end
        // falling edge ends revive; hardware clear beats a write
        if (fall_edge) begin
            ctl_d[bmm_pkg::CTL_REVIVE] = 1'b0;
        end
        // counter saturates so a held-low pin keeps bleed off
        if (data_pin) begin
            low_cnt_d = '0;
        end else if (!disconnect) begin
            low_cnt_d = low_cnt_q + 1'b1;
        end
        if (disconnect) begin
            ctl_d[bmm_pkg::CTL_UPPER_BL] = 1'b0;
            ctl_d[bmm_pkg::CTL_LOWER_BL] = 1'b0;
        end
    end

    // driver states: allow bit and no protection override
    always_comb begin
        charge_fet_d    = ctl_q[bmm_pkg::CTL_CHARGE_ALLOW] && !charge_fault;
        discharge_fet_d = ctl_q[bmm_pkg::CTL_DISCHARGE_ALLOW] && !discharge_fault;
    end

    // read mux; one cycle latency, registered data
    always_comb begin
        rdata_d = bmm_pkg::RESERVED_READ;
        if (!req.rd) begin
            rdata_d = rdata_q;
        end else begin
            unique case (req.page)
                bmm_pkg::PAGE_PROT: begin
                    unique case (req.ofs)
                        bmm_pkg::OFS_PACK_CONTROL:   rdata_d = ctl_rd;
                        bmm_pkg::OFS_DELAY_TIMING:   rdata_d = dly_q;
                        bmm_pkg::OFS_WARN_THRESHOLD: rdata_d = warn_q;
                        bmm_pkg::OFS_IDENT_LO:       rdata_d = ident_q[7:0];
                        bmm_pkg::OFS_IDENT_HI:       rdata_d = ident_q[15:8];
                        default: ;
                    endcase
                end
                bmm_pkg::PAGE_MEAS: begin
                    unique case (req.ofs)
                        bmm_pkg::OFS_PACK_STATUS: rdata_d = meas.status;
                        bmm_pkg::OFS_TEMPERATURE: rdata_d = meas.temperature;
                        bmm_pkg::OFS_LOWER_V_LO:  rdata_d = meas.lower_v[7:0];
                        bmm_pkg::OFS_LOWER_V_HI:  rdata_d = meas.lower_v[15:8];
                        bmm_pkg::OFS_UPPER_V_LO:  rdata_d = meas.upper_v[7:0];
                        bmm_pkg::OFS_UPPER_V_HI:  rdata_d = meas.upper_v[15:8];
                        default: ;
                    endcase
                end
                bmm_pkg::PAGE_ACC: begin
                    unique case (req.ofs)
                        bmm_pkg::OFS_INTEGRATED:   rdata_d = integ_q;
                        bmm_pkg::OFS_CONFIG:       rdata_d = cfg_q;
                        bmm_pkg::OFS_CHARGE_LO:    rdata_d = charge_tot_q[7:0];
                        bmm_pkg::OFS_CHARGE_HI:    rdata_d = charge_tot_q[15:8];
                        bmm_pkg::OFS_DISCHARGE_LO: rdata_d = discharge_tot_q[7:0];
                        bmm_pkg::OFS_DISCHARGE_HI: rdata_d = discharge_tot_q[15:8];
                        bmm_pkg::OFS_CURRENT_LO:   rdata_d = meas.current[7:0];
                        bmm_pkg::OFS_CURRENT_HI:   rdata_d = meas.current[15:8];
                        default: ;
                    endcase
                end
                bmm_pkg::PAGE_USER: rdata_d = user_q[req.ofs];
            endcase
        end
    end

    // registers; accumulators and user bytes are not reset (undefined at power-on)
    always_ff @(posedge core_clk) begin
        integ_q    <= integ_d;
        charge_tot_q    <= charge_tot_d;
        discharge_tot_q <= discharge_tot_d;
        user_q     <= user_d;
        pin_q      <= pin_d;
        if (!rst_b) begin
            ctl_q      <= defaults.control;
            dly_q      <= defaults.delay_timing;
            warn_q     <= defaults.warn_threshold;
            ident_q    <= defaults.identifier;
            cfg_q      <= defaults.configuration | bmm_pkg::CFG_FIXED_ONES;
            lock_q     <= 1'b1;
            low_cnt_q  <= '0;
            charge_fet_q    <= 1'b0;
            discharge_fet_q <= 1'b0;
            rdata_q    <= bmm_pkg::RESERVED_READ;
        end else begin
            ctl_q      <= ctl_d;
            dly_q      <= dly_d;
            warn_q     <= warn_d;
            ident_q    <= ident_d;
            cfg_q      <= cfg_d;
            lock_q     <= lock_d;
            low_cnt_q  <= low_cnt_d;
            charge_fet_q    <= charge_fet_d;
            discharge_fet_q <= discharge_fet_d;
            rdata_q    <= rdata_d;
        end
    end

    // outputs
    assign rdata            = rdata_q;
    assign sleep_request    = ctl_q[bmm_pkg::CTL_SLEEP];
    assign cell_revive_mode = ctl_q[bmm_pkg::CTL_REVIVE];
    assign upper_cell_bleed = ctl_q[bmm_pkg::CTL_UPPER_BL];
    assign lower_cell_bleed = ctl_q[bmm_pkg::CTL_LOWER_BL];
    assign charge_fet_on    = charge_fet_q;
    assign discharge_fet_on = discharge_fet_q;
    assign page_locked      = lock_q;

    // locked page 0 write leaves timing untouched
    // locked refusal
    locked_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.wr && lock_q && !unlock_cmd && req.page == bmm_pkg::PAGE_PROT
        |=> $stable(dly_q) && $stable(warn_q)) else $error("locked page written");
    reserved_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.rd && req.page == bmm_pkg::PAGE_MEAS && req.ofs > bmm_pkg::OFS_UPPER_V_HI
        |=> rdata == bmm_pkg::RESERVED_READ) else $error("reserved not FF");
    revive_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        fall_edge |=> !cell_revive_mode) else $error("revive not cleared");
    bleed_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        disconnect |=> !upper_cell_bleed && !lower_cell_bleed) else $error("bleed on");
    charge_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !ctl_q[bmm_pkg::CTL_CHARGE_ALLOW] |=> !charge_fet_on) else $error("charge on");
    discharge_gate_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        discharge_fault |=> !discharge_fet_on) else $error("discharge on");
    lock_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        lock_cmd |=> page_locked) else $error("lock not set");
    unlock_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        unlock_cmd && !lock_cmd |=> !page_locked) else $error("lock not cleared");
    pin_mirror_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        req.rd && req.page == bmm_pkg::PAGE_PROT && req.ofs == bmm_pkg::OFS_PACK_CONTROL
        |=> rdata[bmm_pkg::CTL_CHARGE_PIN] == $past(charge_fet_on)
        && rdata[bmm_pkg::CTL_DISCHARGE_PIN] == $past(discharge_fet_on))
        else $error("pin mirror wrong");
    acc_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_p2 && req.ofs == bmm_pkg::OFS_CHARGE_LO
        |=> charge_tot_q[7:0] == $past(req.wdata)) else $error("accumulator not written");
    user_store_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_p3 ##1 (req.rd && !req.wr && req.page == bmm_pkg::PAGE_USER
        && req.ofs == $past(req.ofs)) |=> rdata == $past(req.wdata, 2))
        else $error("user byte lost");

endmodule

/* File: rtl/bmm_pkg.sv */
package bmm_pkg;
    // page and offset geometry
    localparam int PAGE_W = 2;
    localparam int OFS_W  = 5;
    localparam int PAGE_BYTES = 32;

    localparam logic [1:0] PAGE_PROT = 2'h0;
    localparam logic [1:0] PAGE_MEAS = 2'h1;
    localparam logic [1:0] PAGE_ACC  = 2'h2;
    localparam logic [1:0] PAGE_USER = 2'h3;

    // page 0 offsets
    localparam logic [4:0] OFS_PACK_CONTROL   = 5'h00;
    localparam logic [4:0] OFS_DELAY_TIMING   = 5'h01;
    localparam logic [4:0] OFS_WARN_THRESHOLD = 5'h02;
    localparam logic [4:0] OFS_IDENT_LO       = 5'h03;
    localparam logic [4:0] OFS_IDENT_HI       = 5'h04;
    // page 1 offsets
    localparam logic [4:0] OFS_PACK_STATUS    = 5'h00;
    localparam logic [4:0] OFS_TEMPERATURE    = 5'h01;
    localparam logic [4:0] OFS_LOWER_V_LO     = 5'h02;
    localparam logic [4:0] OFS_LOWER_V_HI     = 5'h03;
    localparam logic [4:0] OFS_UPPER_V_LO     = 5'h04;
    localparam logic [4:0] OFS_UPPER_V_HI     = 5'h05;
    // page 2 offsets
    localparam logic [4:0] OFS_INTEGRATED     = 5'h00;
    localparam logic [4:0] OFS_CONFIG         = 5'h01;
    localparam logic [4:0] OFS_CHARGE_LO      = 5'h02;
    localparam logic [4:0] OFS_CHARGE_HI      = 5'h03;
    localparam logic [4:0] OFS_DISCHARGE_LO   = 5'h04;
    localparam logic [4:0] OFS_DISCHARGE_HI   = 5'h05;
    localparam logic [4:0] OFS_CURRENT_LO     = 5'h06;
    localparam logic [4:0] OFS_CURRENT_HI     = 5'h07;

    localparam logic [7:0] RESERVED_READ = 8'hFF;

    // control bit positions
    localparam int CTL_SLEEP     = 7;
    localparam int CTL_REVIVE    = 6;
    localparam int CTL_UPPER_BL  = 5;
    localparam int CTL_LOWER_BL  = 4;
    localparam int CTL_CHARGE_PIN      = 3;
    localparam int CTL_DISCHARGE_PIN   = 2;
    localparam int CTL_CHARGE_ALLOW    = 1;
    localparam int CTL_DISCHARGE_ALLOW = 0;

    // bits of page 2 configuration that read as one
    localparam logic [7:0] CFG_FIXED_ONES = 8'h0C;

    // disconnect detection: least low time on the data pin
    localparam int CLK_HZ            = 40000000;
    localparam int DISCONNECT_US     = 2000;
    localparam int DISCONNECT_CYCLES = (CLK_HZ / 1000000) * DISCONNECT_US;
    localparam int DISC_CNT_W        = 17;

    // host access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [1:0] page;
        logic [4:0] ofs;
        logic [7:0] wdata;
    } bmm_req_t;

    // measurement inputs from the analog side
    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  temperature;
        logic [15:0] lower_v;
        logic [15:0] upper_v;
        logic [15:0] current;
    } bmm_meas_t;

    // factory default store
    typedef struct packed {
        logic [7:0]  control;
        logic [7:0]  delay_timing;
        logic [7:0]  warn_threshold;
        logic [15:0] identifier;
        logic [7:0]  configuration;
    } bmm_defaults_t;
endpackage

/* File: dv/bmm_host_model.sv */
`timescale 1ns/100ps
// host side of the access path: issues requests and commands, owns the data line
module bmm_host_model (
    // clock
    input  wire logic         core_clk,
    // requests towards the map
    output bmm_pkg::bmm_req_t req,
    output logic              lock_cmd,
    output logic              unlock_cmd,
    output logic              data_pin,
    // answer
    input  wire logic [7:0]   rdata
);
    // idle state: no strobes, data line sits at its pull-up level
    initial begin
        req        = '0;
        lock_cmd   = 1'b0;
        unlock_cmd = 1'b0;
        data_pin   = 1'b1;
    end

    task automatic write(input logic [1:0] pg, input logic [4:0] ofs, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{rd: 1'b0, wr: 1'b1, page: pg, ofs: ofs, wdata: d};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    // rdata lands one cycle after the read edge, sampled once settled
    task automatic read(input logic [1:0] pg, input logic [4:0] ofs, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{rd: 1'b1, wr: 1'b0, page: pg, ofs: ofs, wdata: 8'h00};
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(posedge core_clk);
        #1 d = rdata;
    endtask

    // write then read the same byte on the very next edge, no idle cycle between
    task automatic write_read(input logic [1:0] pg, input logic [4:0] ofs,
                              input logic [7:0] wd, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{rd: 1'b0, wr: 1'b1, page: pg, ofs: ofs, wdata: wd};
        @(posedge core_clk);
        req <= '{rd: 1'b1, wr: 1'b0, page: pg, ofs: ofs, wdata: wd};
        @(posedge core_clk);
        req.rd <= 1'b0;
        @(posedge core_clk);
        #1 d = rdata;
    endtask

    // one-cycle command pulse, lock when set, unlock otherwise
    task automatic pulse_cmd(input logic lock);
        @(posedge core_clk);
        lock_cmd   <= lock;
        unlock_cmd <= ~lock;
        @(posedge core_clk);
        lock_cmd   <= 1'b0;
        unlock_cmd <= 1'b0;
    endtask

    // pull the data line low for n cycles, then let the pull-up take it back
    task automatic line_low(input int n);
        @(posedge core_clk);
        data_pin <= 1'b0;
        repeat (n) @(posedge core_clk);
        data_pin <= 1'b1;
    endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    // design signals
    logic                   core_clk;
    logic                   rst_b;
    bmm_pkg::bmm_req_t      req;
    logic [7:0]             rdata;
    logic                   lock_cmd;
    logic                   unlock_cmd;
    logic                   data_pin;
    bmm_pkg::bmm_meas_t     meas;
    bmm_pkg::bmm_defaults_t defaults;
    logic                   charge_fault;
    logic                   discharge_fault;
    logic                   sleep_request;
    logic                   cell_revive_mode;
    logic                   upper_cell_bleed;
    logic                   lower_cell_bleed;
    logic                   charge_fet_on;
    logic                   discharge_fet_on;
    logic                   page_locked;
    int                     num_errors;
    int                     checked;
    logic [7:0]             wv [4] = '{8'h70, 8'hB2, 8'h01, 8'h03};
    logic [7:0]             mv [6] = '{8'hA0, 8'h19, 8'h34, 8'h02, 8'h56, 8'h03}; // page 1 bytes
    logic [7:0]             rb;

    bmm_host_model host (.core_clk(core_clk), .req(req), .lock_cmd(lock_cmd),
        .unlock_cmd(unlock_cmd), .data_pin(data_pin), .rdata(rdata));

    bmm_memory_map dut (.core_clk(core_clk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .lock_cmd(lock_cmd), .unlock_cmd(unlock_cmd), .data_pin(data_pin), .meas(meas),
        .defaults(defaults), .charge_fault(charge_fault), .discharge_fault(discharge_fault),
        .sleep_request(sleep_request), .cell_revive_mode(cell_revive_mode),
        .upper_cell_bleed(upper_cell_bleed), .lower_cell_bleed(lower_cell_bleed),
        .charge_fet_on(charge_fet_on), .discharge_fet_on(discharge_fet_on),
        .page_locked(page_locked));

    // 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [1:0] pg, input logic [4:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        host.read(pg, ofs, d);
        check_byte($sformatf("p%0d_o%0h", pg, ofs), exp, d);
    endtask

    // control readback: pin mirrors follow allow bits gated by faults
    function automatic logic [7:0] ctl_exp(input logic [7:0] w);
        return {w[7:4], w[1] & ~charge_fault, w[0] & ~discharge_fault, w[1:0]};
    endfunction

    function automatic logic [7:0] outs();
        return {2'b00, sleep_request, cell_revive_mode, upper_cell_bleed, lower_cell_bleed,
                charge_fet_on, discharge_fet_on};
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // watchdog sized for the long disconnect wait plus margin
    initial begin
        repeat (95000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        num_errors      = 0;
        checked         = 0;
        rst_b           = 1'b0;
        charge_fault    = 1'b0;
        discharge_fault = 1'b0;
        // identifier value is arbitrary
        defaults = '{control: 8'h03, delay_timing: 8'h11, warn_threshold: 8'h22,
                     identifier: 16'hB7C4, configuration: 8'hF1};
        meas = '{status: 8'hA0, temperature: 8'h19, lower_v: 16'h0234,
                 upper_v: 16'h0356, current: 16'hFE10};
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1 check_byte("lock_rst", 8'h01, {7'h00, page_locked});
        check_byte("rdata_rst", 8'hFF, rdata);
        rd_chk(2'h0, 5'h00, ctl_exp(8'h03));
        check_byte("outs_rst", 8'h03, outs());
        rd_chk(2'h0, 5'h01, 8'h11);
        rd_chk(2'h0, 5'h02, 8'h22);
        rd_chk(2'h0, 5'h03, 8'hC4);
        rd_chk(2'h0, 5'h04, 8'hB7);
        rd_chk(2'h2, 5'h01, 8'hF1 | bmm_pkg::CFG_FIXED_ONES);
        // writes to a locked page are dropped
        host.write(2'h0, 5'h01, 8'h5A);
        rd_chk(2'h0, 5'h01, 8'h11);
        host.write(2'h0, 5'h00, 8'h30);
        rd_chk(2'h0, 5'h00, ctl_exp(8'h03));
        host.pulse_cmd(1'b0);
        #1 check_byte("unlocked", 8'h00, {7'h00, page_locked});
        host.write(2'h0, 5'h01, 8'h5A);
        rd_chk(2'h0, 5'h01, 8'h5A);
        host.write(2'h0, 5'h03, 8'h00);
        rd_chk(2'h0, 5'h03, 8'hC4);
        // every control bit set and cleared through the table
        foreach (wv[i]) begin
            host.write(2'h0, 5'h00, wv[i]);
            rd_chk(2'h0, 5'h00, ctl_exp(wv[i]));
            check_byte("outs", {2'b00, wv[i][7:4], wv[i][1:0]}, outs());
        end
        // protection overrides one driver at a time
        @(posedge core_clk);
        charge_fault <= 1'b1;
        rd_chk(2'h0, 5'h00, 8'h07);
        check_byte("fets_cf", 8'h01, outs());
        @(posedge core_clk);
        charge_fault    <= 1'b0;
        discharge_fault <= 1'b1;
        rd_chk(2'h0, 5'h00, 8'h0B);
        check_byte("fets_df", 8'h02, outs());
        @(posedge core_clk);
        discharge_fault <= 1'b0;
        // falling edge on the data line ends revive mode
        host.write(2'h0, 5'h00, 8'h43);
        host.line_low(1);
        rd_chk(2'h0, 5'h00, 8'h0F);
        // measurement page is live and refuses writes
        for (int i = 0; i < 6; i++)
            rd_chk(2'h1, 5'(i), mv[i]);
        host.write(2'h1, 5'h01, 8'h00);
        rd_chk(2'h1, 5'h01, 8'h19);
        host.write(2'h2, 5'h06, 8'h00);
        rd_chk(2'h2, 5'h06, 8'h10);
        rd_chk(2'h2, 5'h07, 8'hFE);
        for (int i = 0; i < 6; i++) begin
            if (i != 1) host.write(2'h2, 5'(i), 8'(8'h90 + i));
            if (i != 1) rd_chk(2'h2, 5'(i), 8'(8'h90 + i));
        end
        for (int i = 0; i < 32; i++)
            host.write(2'h3, 5'(i), 8'(i) ^ 8'h5C);
        for (int i = 0; i < 32; i++)
            rd_chk(2'h3, 5'(i), 8'(i) ^ 8'h5C);
        // back-to-back write and read of one user byte
        host.write_read(2'h3, 5'h05, 8'hAA, rb);
        check_byte("wr_rd", 8'hAA, rb);
        // reserved bytes read FF even after a write
        for (int p = 0; p < 3; p++) begin
            for (int o = (p == 0) ? 5 : (p == 1) ? 6 : 8; o < 32; o++) begin
                host.write(2'(p), 5'(o), 8'h00);
                rd_chk(2'(p), 5'(o), bmm_pkg::RESERVED_READ);
            end
        end
        // long low on the data line drops both bleeds
        host.write(2'h0, 5'h00, 8'h33);
        host.line_low(bmm_pkg::DISCONNECT_CYCLES + 4);
        #1 check_byte("bleeds", 8'h03, outs());
        host.pulse_cmd(1'b1);
        #1 check_byte("relocked", 8'h01, {7'h00, page_locked});
        host.write(2'h0, 5'h02, 8'h77);
        rd_chk(2'h0, 5'h02, 8'h22);
        stop_test();
    end
endmodule
